// [design/mcct_cfg.svh]
/*
  constants for the match/capture counter timer: widths, field codes,
  reset values. assumes inclusion by bare name from design files.
*/
`ifndef MCCT_CFG_SVH
`define MCCT_CFG_SVH

`define MCCT_WIDE_W 32
`define MCCT_NARROW_W 16
`define MCCT_NUM_MATCH 4
`define MCCT_EXT_NOTHING 2'h0
`define MCCT_EXT_LOW 2'h1
`define MCCT_EXT_HIGH 2'h2
`define MCCT_EXT_TOGGLE 2'h3
`define MCCT_EDGE_RISE 2'h1
`define MCCT_EDGE_FALL 2'h2
`define MCCT_SYNC_FILL 2'h3
`define MCCT_ZERO_32 32'h0000_0000
`define MCCT_ONE_32 32'h0000_0001

`endif

// [design/mcct_pkg.sv]
/*
  types for the match/capture counter timer.
  assumes nothing beyond a systemverilog compiler.
*/
package mcct_pkg;
  // counting source
  typedef enum logic {
    MCCT_MODE_TIMER = 1'b0,
    MCCT_MODE_COUNTER = 1'b1
  } mcct_mode_type;
endpackage

// [design/mcct_sync.sv]
/*
  three-flop input synchroniser with agreement-based change detection.
  assumes the input is asynchronous to ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mcct_cfg.svh"
module mcct_sync (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // pin side
  input wire logic pinIn,
  // synchronised level and edges
  output logic level,
  output logic rise,
  output logic fall
);
  logic [2:0] stage;
  logic [2:0] next_stage;
  logic next_level;
  logic [1:0] fill;
  logic [1:0] next_fill;
  logic armed;

  // shift chain; level moves only when stages two and three agree
  // while the chain fills after reset, level preloads with no edge,
  // so a pin idling high does not report a false rise
  always_comb begin
    next_stage = {stage[1:0], pinIn};
    armed = (fill == `MCCT_SYNC_FILL);
    next_fill = armed ? fill : fill + 2'h1;
    if (armed) begin
      next_level = (stage[2] == stage[1]) ? stage[2] : level;
    end else begin
      next_level = stage[1];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage <= 3'h0;
      level <= 1'b0;
      fill <= 2'h0;
    end else begin
      stage <= next_stage;
      level <= next_level;
      fill <= next_fill;
    end
  end

  assign rise = armed & next_level & ~level;
  assign fall = armed & ~next_level & level;
endmodule
`default_nettype wire

// [design/mcct_timer.sv]
/*
  one counter/timer instance: prescaler, counter, four match channels,
  one capture channel, interrupt flags and adc trigger pulses.
  assumes control ports are steady from ref_clk logic; the event and
  capture inputs are pins and are synchronised here. four instances of
  this module (two at 32 bits, two at 16 bits) make up the full set.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mcct_cfg.svh"
// Summary of operation
// - two wide, two narrow instances, same logic
// - timer mode counts prescaled system clock cycles
// - prescaler width equals counter width
// - counter mode counts external input transitions
// - four match registers compared against counter
// - match may interrupt while counter keeps running
// - match may stop counting, optional interrupt
// - match may reset counter, optional interrupt
// - four external outputs, one per match
// - output low, high, toggle or unchanged
// - capture copies counter on input transition
// - capture raises interrupt when enabled
// - designated capture edge clears counter and prescaler
// - match and capture events trigger adc
module mcct_timer
  import mcct_pkg::*;
#(
  parameter int WIDTH = `MCCT_WIDE_W
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // run control and counting source
  input wire logic runEnable,
  input wire mcct_mode_type countMode,
  input wire logic [1:0] countEdge,
  input wire logic [WIDTH-1:0] prescaleLimit,
  // match configuration, packed per channel
  input wire logic [4*WIDTH-1:0] matchValue,
  input wire logic [3:0] matchIrqEnable,
  input wire logic [3:0] matchStop,
  input wire logic [3:0] matchReset,
  input wire logic [7:0] extAction,
  input wire logic [3:0] pwmEnable,
  // capture configuration
  input wire logic [1:0] captureEdge,
  input wire logic captureIrqEnable,
  input wire logic [1:0] clearEdge,
  // flag clear, one bit per match then capture
  input wire logic [4:0] flagClear,
  // pins
  input wire logic eventPin,
  input wire logic capturePin,
  // observed state
  output logic [WIDTH-1:0] count,
  output logic [WIDTH-1:0] prescaleCount,
  output logic [WIDTH-1:0] captureValue,
  output logic running,
  output logic [3:0] matchOut,
  output logic [4:0] flags,
  output logic irq,
  output logic [3:0] adcMatchTrig,
  output logic adcCaptureTrig
);
  // synchronised pin edges
  logic evRise;
  logic evFall;
  logic capRise;
  logic capFall;
  // next values of the registered state
  logic [WIDTH-1:0] next_count, next_prescaleCount, next_captureValue;
  logic next_running;
  logic next_halted;
  logic next_irq;
  logic next_adcCaptureTrig;
  logic [3:0] next_matchOut;
  logic [3:0] next_adcMatchTrig;
  logic [4:0] next_flags;
  // per-cycle decode
  logic [3:0] hit;
  logic [4:0] event5;
  logic tick;
  logic capEvent;
  logic clrEvent;
  logic restart;
  logic stopHit;
  // set by a stop match, cleared by lowering runEnable or by sys_rst
  logic halted;

  // edge selection used by counting, capture and clear
  function automatic logic edgeSel(input logic [1:0] sel,
                                   input logic r, input logic f);
    edgeSel = (sel[0] & r) | (sel[1] & f);
  endfunction

  // pin synchronisers
  mcct_sync evSync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pinIn(eventPin),
    .level(),
    .rise(evRise),
    .fall(evFall)
  );

  mcct_sync capSync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pinIn(capturePin),
    .level(),
    .rise(capRise),
    .fall(capFall)
  );

  // match comparison per channel
  genvar gi;
  generate
    for (gi = 0; gi < `MCCT_NUM_MATCH; gi++) begin : gMatch
      assign hit[gi] = running &&
        (count == matchValue[gi*WIDTH +: WIDTH]);
    end
  endgenerate

  // counter, prescaler, capture and match output next state
  always_comb begin
    next_prescaleCount = prescaleCount;
    next_count = count;
    stopHit = |(hit & matchStop);
    // without the halt latch a held runEnable would restart at once
    next_halted = runEnable & (halted | stopHit);
    next_running = runEnable & ~stopHit & ~halted;
    next_captureValue = captureValue;
    next_matchOut = matchOut;
    tick = 1'b0;
    restart = 1'b0;
    capEvent = edgeSel(captureEdge, capRise, capFall);
    clrEvent = edgeSel(clearEdge, capRise, capFall);
    if (running) begin
      if (countMode == MCCT_MODE_COUNTER) begin
        tick = edgeSel(countEdge, evRise, evFall);
      end else if (prescaleCount >= prescaleLimit) begin
        next_prescaleCount = WIDTH'(`MCCT_ZERO_32);
        tick = 1'b1;
      end else begin
        next_prescaleCount = prescaleCount + WIDTH'(`MCCT_ONE_32);
      end
    end
    if (stopHit) begin
      next_running = 1'b0;
    end else if (|(hit & matchReset)) begin
      if (tick) begin
        next_count = WIDTH'(`MCCT_ZERO_32);
        restart = 1'b1;
      end
    end else if (tick) begin
      next_count = count + WIDTH'(`MCCT_ONE_32);
      restart = (next_count == WIDTH'(`MCCT_ZERO_32));
    end
    if (clrEvent) begin
      next_count = WIDTH'(`MCCT_ZERO_32);
      next_prescaleCount = WIDTH'(`MCCT_ZERO_32);
      restart = 1'b1;
    end
    if (capEvent) begin
      next_captureValue = count;
    end
    for (int i = 0; i < `MCCT_NUM_MATCH; i++) begin
      if (pwmEnable[i]) begin
        if (hit[i]) begin
          next_matchOut[i] = 1'b0;
        end else if (restart) begin
          next_matchOut[i] = 1'b1;
        end
      end else if (hit[i] && tick) begin
        unique case (extAction[2*i +: 2])
          `MCCT_EXT_LOW: next_matchOut[i] = 1'b0;
          `MCCT_EXT_HIGH: next_matchOut[i] = 1'b1;
          `MCCT_EXT_TOGGLE: next_matchOut[i] = ~matchOut[i];
          `MCCT_EXT_NOTHING: next_matchOut[i] = matchOut[i];
        endcase
      end
    end
  end

  // flags: set wins over software clear, request while enabled flag set
  always_comb begin
    event5 = {capEvent, hit}; // every hit sets its flag
    next_flags = (flags & ~flagClear) | event5;
    next_irq = |(next_flags & {captureIrqEnable, matchIrqEnable});
    next_adcMatchTrig = hit;
    next_adcCaptureTrig = capEvent;
  end

  // state registers
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= WIDTH'(`MCCT_ZERO_32);
      prescaleCount <= WIDTH'(`MCCT_ZERO_32);
      captureValue <= WIDTH'(`MCCT_ZERO_32);
      running <= 1'b0;
      halted <= 1'b0;
      matchOut <= 4'h0;
      flags <= 5'h00;
      irq <= 1'b0;
      adcMatchTrig <= 4'h0;
      adcCaptureTrig <= 1'b0;
    end else begin
      count <= next_count;
      prescaleCount <= next_prescaleCount;
      captureValue <= next_captureValue;
      running <= next_running;
      halted <= next_halted;
      matchOut <= next_matchOut;
      flags <= next_flags;
      irq <= next_irq;
      adcMatchTrig <= next_adcMatchTrig;
      adcCaptureTrig <= next_adcCaptureTrig;
    end
  end
endmodule
`default_nettype wire

// [sim/mcct_timer_monitor.sv]
/* port assertions for one timer instance.
   assumes the bind below reaches every mcct_timer. */
`timescale 1ns/1ps
`default_nettype none
module mcct_timer_monitor
  import mcct_pkg::*;
#(parameter int WIDTH = 32) (
  // clock, reset and controls
  input wire logic ref_clk, sys_rst, runEnable,
  input wire mcct_mode_type countMode,
  input wire logic [WIDTH-1:0] prescaleLimit,
  input wire logic [4*WIDTH-1:0] matchValue,
  input wire logic [3:0] matchIrqEnable, matchStop, matchReset,
  input wire logic captureIrqEnable,
  input wire logic [1:0] clearEdge,
  input wire logic [4:0] flagClear,
  // observed state
  input wire logic [WIDTH-1:0] count,
  input wire logic running, irq, adcCaptureTrig,
  input wire logic [3:0] adcMatchTrig,
  input wire logic [4:0] flags
);
  logic [4:0] irqEnables;
  logic hit0;
  // interrupt enables per flag, channel 0 match while running
  assign irqEnables = {captureIrqEnable, matchIrqEnable};
  assign hit0 = running && count == matchValue[WIDTH-1:0];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // undivided timer counting with no match action
  sequence fastTick;
    running && runEnable && countMode == MCCT_MODE_TIMER &&
      prescaleLimit == '0 && matchReset == '0 &&
      matchStop == '0 && clearEdge == '0;
  endsequence
  tick_step_a: assert property (
    fastTick |=> count == $past(count) + 1'b1) else $error("no step");
  stop_run_a: assert property (
    running && matchStop[1] && count == matchValue[WIDTH +: WIDTH]
    |-> ##[1:2] !running) else $error("no stop");
  match_flag_a: assert property (hit0 |=> flags[0])
    else $error("no match flag");
  match_adc_a: assert property (hit0 |=> adcMatchTrig[0])
    else $error("no match trigger");
  flag_keep_a: assert property (
    flags[0] && !flagClear[0] |=> flags[0]) else $error("flag lost");
  irq_flags_a: assert property (
    1'b1 |=> irq == |(flags & $past(irqEnables)))
    else $error("irq mismatch");
  cap_pulse_a: assert property (
    adcCaptureTrig |=> !adcCaptureTrig) else $error("long pulse");
  run_start_a: assert property (
    $rose(runEnable) |=> running) else $error("no start");
  halt_hold_a: assert property (
    !running && runEnable && $past(runEnable) |=> !running)
    else $error("restart without rearm");
endmodule
bind mcct_timer mcct_timer_monitor #(.WIDTH(WIDTH)) mon (.ref_clk,
  .sys_rst, .runEnable, .countMode, .prescaleLimit, .matchValue,
  .matchIrqEnable, .matchStop, .matchReset, .captureIrqEnable,
  .clearEdge, .flagClear, .count, .running, .irq, .adcCaptureTrig,
  .adcMatchTrig, .flags);
`default_nettype wire

// [sim/testbench.sv]
/* bench for one narrow timer, results against an integer model.
   assumes package, design and monitor are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mcct_pkg::*;
  localparam int W = 16;
  // inputs
  logic ref_clk = 1'b0, sys_rst = 1'b1, runEnable = 1'b0, eventPin = 1'b0;
  logic capturePin = 1'b0, captureIrqEnable = 1'b0;
  mcct_mode_type countMode = MCCT_MODE_TIMER;
  logic [1:0] countEdge = 2'h0, captureEdge = 2'h0, clearEdge = 2'h0;
  logic [W-1:0] prescaleLimit = 16'h0;
  logic [4*W-1:0] matchValue = 64'h0;
  logic [3:0] matchIrqEnable = 4'h0, matchStop = 4'h0, matchReset = 4'h0;
  logic [3:0] pwmEnable = 4'h0;
  logic [7:0] extAction = 8'h0;
  logic [4:0] flagClear = 5'h0;
  // outputs
  logic [W-1:0] count, captureValue, psc;
  logic running, irq, adcCaptureTrig;
  logic [3:0] matchOut;
  logic [4:0] flags;
  int mismatches = 0, cmp_count = 0, t, n, prv, wraps;
  // 25 mhz clock
  always #20 ref_clk = ~ref_clk;
  mcct_timer #(.WIDTH(W)) dut (.ref_clk, .sys_rst, .runEnable, .countMode,
    .countEdge, .prescaleLimit, .matchValue, .matchIrqEnable, .matchStop,
    .matchReset, .extAction, .pwmEnable, .captureEdge,
    .captureIrqEnable, .clearEdge, .flagClear, .eventPin, .capturePin,
    .count, .prescaleCount(psc), .captureValue, .running, .matchOut, .flags,
    .irq, .adcMatchTrig(), .adcCaptureTrig);
  task automatic tick(int k);
    repeat (k) @(posedge ref_clk);
  endtask
  task automatic check(string what, logic [W-1:0] seen, logic [W-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // bounded wait for a count value; t is the cycles spent
  task automatic waitCount(int v);
    for (t = 0; count !== W'(v) && t < 300; t++) tick(1);
  endtask
  // reset again, settings kept
  task automatic restart();
    runEnable <= 1'b0;
    sys_rst <= 1'b1;
    tick(2);
    sys_rst <= 1'b0;
    tick(1);
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // cut a hang short
  initial begin
    #100us;
    mismatches++;
    results();
  end
  initial begin
    void'($urandom(32'h86ec));
    tick(16);
    sys_rst <= 1'b0;
    tick(1);
    // undivided, then a random divisor
    runEnable <= 1'b1;
    tick(6);
    prescaleLimit <= W'($urandom_range(3));
    n = count + 3;
    waitCount(n);
    waitCount(n + 1);
    check("period", W'(t), prescaleLimit + 16'h1);
    check("prescale", psc, 16'h0);
    // reset on channel 0, one output action per channel
    prescaleLimit <= 16'h0;
    matchValue <= {4{16'h5}};
    matchReset <= 4'h1;
    matchIrqEnable <= 4'h1;
    extAction <= 8'h1b;
    restart();
    runEnable <= 1'b1;
    n = 0;
    prv = 0;
    wraps = 0;
    for (int i = 0; i < 44; i++) begin
      tick(1);
      if (i == 40) runEnable <= 1'b0;
      if (count > n) n = count;
      if (prv == 5 && count !== 16'h5) wraps++;
      prv = count;
    end
    check("top", W'(n), 16'h5);
    check("outputs", W'(matchOut), {13'h0, 2'h1, wraps[0]});
    check("flags", W'(flags), 16'hf);
    check("irq", W'(irq), 16'h1);
    flagClear <= 5'h1f;
    tick(1);
    flagClear <= 5'h0;
    tick(3);
    check("cleared", W'({flags, irq}), 16'h0);
    // stop at a random value of channel 1
    n = $urandom_range(40, 3);
    matchValue <= {4{W'(n)}};
    matchReset <= 4'h0;
    matchStop <= 4'h2;
    restart();
    runEnable <= 1'b1;
    tick(60);
    check("running", W'(running), 16'h0);
    check("held", count, W'(n));
    // pwm on channel 0, period set by a reset match on channel 3
    matchStop <= 4'h0;
    matchValue <= {16'h7, 16'h0, 16'h0, 16'h3};
    matchReset <= 4'h8;
    pwmEnable <= 4'h1;
    restart();
    runEnable <= 1'b1;
    waitCount(7);
    repeat (16) begin
      tick(1);
      check("pwm", W'(matchOut[0]), W'(count <= 16'h3));
    end
    // count event pin edges
    matchReset <= 4'h0;
    pwmEnable <= 4'h0;
    countMode <= MCCT_MODE_COUNTER;
    countEdge <= 2'h3;
    restart();
    runEnable <= 1'b1;
    n = $urandom_range(9, 2);
    repeat (n) begin
      tick(6);
      eventPin <= ~eventPin;
    end
    tick(8);
    check("events", count, W'(n));
    // pulse width: clear on fall, capture on rise
    countMode <= MCCT_MODE_TIMER;
    captureEdge <= 2'h1;
    clearEdge <= 2'h2;
    captureIrqEnable <= 1'b1;
    matchIrqEnable <= 4'h0;
    capturePin <= 1'b1;
    restart();
    runEnable <= 1'b1;
    tick(20);
    capturePin <= 1'b0;
    n = $urandom_range(30, 10);
    tick(n);
    capturePin <= 1'b1;
    prv = 0;
    repeat (8) begin
      tick(1);
      if (adcCaptureTrig === 1'b1) prv++;
    end
    check("trigger", W'(prv), 16'h1);
    check("capflag", W'(flags[4] & irq), 16'h1);
    t = captureValue;
    check("width", W'(t >= n - 1 && t <= n + 1), 16'h1);
    results();
  end
endmodule
`default_nettype wire
